// ---- hdl/aoc_pkg.sv ----
/*
 * Shared constants and types for the converter output configuration slice:
 * register addresses, reset values, field positions, format and test-mode codes.
 * Assumes an 8-bit register address space written by an on-chip serial port.
 */
package aoc_pkg;

  localparam logic [7:0] ADDR_SELF_TEST   = 8'h0E;
  localparam logic [7:0] ADDR_OFFSET_TRIM = 8'h10;
  localparam logic [7:0] ADDR_OUT_FORMAT  = 8'h14;
  localparam logic [7:0] ADDR_DRIVE       = 8'h15;
  localparam logic [7:0] ADDR_CLK_PHASE   = 8'h16;
  localparam logic [7:0] ADDR_FINE_DELAY  = 8'h17;
  localparam logic [7:0] ADDR_USER_LOW    = 8'h19;
  localparam logic [7:0] ADDR_USER_HIGH   = 8'h1A;

  localparam logic [7:0] RST_SELF_TEST    = 8'h00;
  localparam logic [7:0] RST_OFFSET_TRIM  = 8'h00;
  localparam logic [7:0] RST_OUT_FORMAT   = 8'h00;
  localparam logic [7:0] RST_DRIVE        = 8'h22;
  localparam logic [7:0] RST_CLK_PHASE    = 8'h00;
  localparam logic [7:0] RST_FINE_DELAY   = 8'h00;
  localparam logic [7:0] RST_USER_LOW     = 8'h00;
  localparam logic [7:0] RST_USER_HIGH    = 8'h00;

  // Writable bits per register; open bits read zero
  localparam logic [7:0] MASK_SELF_TEST   = 8'h05;
  localparam logic [7:0] MASK_FMT_LOCAL   = 8'h17;
  localparam logic [7:0] MASK_FMT_GLOBAL  = 8'hE0;
  localparam logic [7:0] MASK_CLK_PHASE   = 8'h87;
  localparam logic [7:0] MASK_FINE_DELAY  = 8'hA7;

  localparam int BIT_SELF_TEST_EN   = 0;
  localparam int BIT_SELF_TEST_INIT = 2;
  localparam int BIT_INVERT         = 2;
  localparam int BIT_OUT_DISABLE    = 4;
  localparam int BIT_MUX_EN         = 5;
  localparam int BIT_SUPPLY_1V8     = 7;
  localparam int BIT_DCO_INVERT     = 7;
  localparam int BIT_DCO_DLY_EN     = 7;
  localparam int BIT_DATA_DLY_EN    = 5;

  localparam logic [1:0] FMT_TWOS   = 2'h1;
  localparam logic [1:0] FMT_GRAY   = 2'h2;
  localparam logic [1:0] FMT_OFFBIN = 2'h3;

  localparam logic [3:0] TEST_USER_INPUT = 4'h8;

  localparam logic [2:0] PHASE_MAX      = 3'h6;
  localparam logic [2:0] FINE_CODE_MAX  = 3'h6;
  localparam int         FINE_STEP_PS   = 560;

  localparam int CLK_PERIOD_NS   = 50;
  localparam int BIST_TIME_NS    = 12800;
  localparam int BIST_CYCLES     = (BIST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] BIST_SEED = 16'hFFFF;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] chan_sel;
    logic [7:0] addr;
    logic [7:0] wdata;
  } aoc_cfg_req_t;

  typedef struct packed {
    logic       clk_en;
    logic       data_en;
    logic [2:0] code;
  } aoc_fine_dly_t;

endpackage

// ---- hdl/aoc_phase_delay.sv ----
/*
 * Whole-cycle delay of the per-sample divider strobe that forms the output
 * data clock; also applies its polarity.
 * Assumes strobe_i is a one-cycle pulse from logic on sys_clk_i.
 */
`timescale 1ns/10ps
module aoc_phase_delay
  import aoc_pkg::*;
#(
  parameter int MAX_DLY = 6
) (
  input  wire logic       sys_clk_i,  // System clock
  input  wire logic       nrst_i,     // Async reset, active low
  input  wire logic       strobe_i,   // Divider output strobe
  input  wire logic [2:0] phase_i,    // Delay in input clock cycles
  input  wire logic       invert_i,   // Output polarity
  output logic            dco_o       // Delayed data clock
);

  logic [MAX_DLY-1:0] tap_r;
  logic [2:0]         sel;
  logic               tap_sel;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tap_r <= '0;
    end else begin
      tap_r <= {tap_r[MAX_DLY-2:0], strobe_i};
    end
  end

  // Codes above the top step clamp rather than alias to a short delay
  assign sel = (phase_i > PHASE_MAX) ? PHASE_MAX : phase_i;

  always_comb begin
    tap_sel = strobe_i;
    if (sel != 3'h0) begin
      tap_sel = tap_r[sel-3'h1];
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dco_o <= 1'b0;
    end else begin
      dco_o <= tap_sel ^ invert_i;
    end
  end

endmodule

// ---- hdl/aoc_output_config.sv ----
/*
 * Output configuration register slice of a dual 12-bit converter: self-test,
 * offset trim, data format, drive strength, clock phase, fine delay and the
 * first user test word, plus the output formatting they steer.
 * Assumes the serial port engine and the converter core sit on sys_clk_i.
 */

`timescale 1ns/10ps
module aoc_output_config
  import aoc_pkg::*;
#(
  parameter int BIST_LEN = BIST_CYCLES
) (
  input  wire logic          sys_clk_i,        // System clock, 20 MHz
  input  wire logic          nrst_i,           // Async reset, active low
  input  aoc_cfg_req_t       cfg_req_i,        // Register access request
  output logic [7:0]         cfg_rdata_o,      // Read data
  output logic               cfg_ack_o,        // Access done pulse
  input  wire logic          sample_strobe_i,  // Divider strobe, one per sample
  input  wire logic [11:0]   sample_a_i,       // Channel A code, offset binary
  input  wire logic [11:0]   sample_b_i,       // Channel B code, offset binary
  input  wire logic [3:0]    test_mode_a_i,    // Channel A test mode select
  input  wire logic [3:0]    test_mode_b_i,    // Channel B test mode select
  output logic [11:0]        data_a_o,         // Channel A output word
  output logic [11:0]        data_b_o,         // Channel B output word
  output logic [1:0]         data_en_o,        // Per-channel output enable
  output logic               data_clock_out_o, // Output data clock
  output logic [3:0]         data_stripes_o,   // Data driver stripe enables
  output logic [3:0]         dco_stripes_o,    // Clock driver stripe enables
  output aoc_fine_dly_t      fine_dly_o,       // Fine delay cell control
  output logic               self_test_busy_o, // Self-test running
  output logic [15:0]        self_test_sig_o   // Self-test signature
);

  logic [7:0]  self_test_r;
  logic [7:0]  offset_r     [2];
  logic [7:0]  fmt_local_r  [2];
  logic [7:0]  fmt_global_r;
  logic [7:0]  drive_r;
  logic [7:0]  phase_r;
  logic [7:0]  delay_r;
  logic [7:0]  user_low_r;
  logic [7:0]  user_high_r;
  logic        rd_sel;
  logic [7:0]  rdata_nxt;

  assign rd_sel = cfg_req_i.chan_sel[0] ? 1'b0 : 1'b1;

  // Register writes; local registers go to every indexed channel
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      self_test_r  <= RST_SELF_TEST;
      fmt_global_r <= RST_OUT_FORMAT;
      drive_r      <= RST_DRIVE;
      phase_r      <= RST_CLK_PHASE;
      delay_r      <= RST_FINE_DELAY;
      user_low_r   <= RST_USER_LOW;
      user_high_r  <= RST_USER_HIGH;
    end else if (cfg_req_i.wr) begin
      unique case (cfg_req_i.addr)
        ADDR_SELF_TEST:  self_test_r  <= cfg_req_i.wdata & MASK_SELF_TEST;
        ADDR_OUT_FORMAT: fmt_global_r <= cfg_req_i.wdata & MASK_FMT_GLOBAL;
        ADDR_DRIVE:      drive_r      <= cfg_req_i.wdata;
        ADDR_CLK_PHASE:  phase_r      <= cfg_req_i.wdata & MASK_CLK_PHASE;
        ADDR_FINE_DELAY: delay_r      <= cfg_req_i.wdata & MASK_FINE_DELAY;
        ADDR_USER_LOW:   user_low_r   <= cfg_req_i.wdata;
        ADDR_USER_HIGH:  user_high_r  <= cfg_req_i.wdata;
        default: ;
      endcase
    end
  end

  genvar gc;
  generate
    for (gc = 0; gc < 2; gc++) begin : g_local_reg
      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          offset_r[gc]    <= RST_OFFSET_TRIM;
          fmt_local_r[gc] <= RST_OUT_FORMAT;
        end else if (cfg_req_i.wr && cfg_req_i.chan_sel[gc]) begin
          if (cfg_req_i.addr == ADDR_OFFSET_TRIM) begin
            offset_r[gc] <= cfg_req_i.wdata;
          end
          if (cfg_req_i.addr == ADDR_OUT_FORMAT) begin
            fmt_local_r[gc] <= cfg_req_i.wdata & MASK_FMT_LOCAL;
          end
        end
      end
    end
  endgenerate

  // Read mux; unmapped addresses answer zero
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (cfg_req_i.addr)
      ADDR_SELF_TEST:   rdata_nxt = self_test_r;
      ADDR_OFFSET_TRIM: rdata_nxt = offset_r[rd_sel];
      ADDR_OUT_FORMAT:  rdata_nxt = fmt_global_r | fmt_local_r[rd_sel];
      ADDR_DRIVE:       rdata_nxt = drive_r;
      ADDR_CLK_PHASE:   rdata_nxt = phase_r;
      ADDR_FINE_DELAY:  rdata_nxt = delay_r;
      ADDR_USER_LOW:    rdata_nxt = user_low_r;
      ADDR_USER_HIGH:   rdata_nxt = user_high_r;
      default:          rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_rdata_o <= 8'h00;
    end else if (cfg_req_i.rd) begin
      cfg_rdata_o <= rdata_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_ack_o <= 1'b0;
    end else begin
      cfg_ack_o <= cfg_req_i.wr | cfg_req_i.rd;
    end
  end

  // Thermometer stripe enables from a two-bit drive code
  function automatic logic [3:0] stripes(input logic [1:0] code);
    unique case (code)
      2'h0: stripes = 4'h1;
      2'h1: stripes = 4'h3;
      2'h2: stripes = 4'h7;
      2'h3: stripes = 4'hF;
    endcase
  endfunction

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_stripes_o <= 4'h1;
      dco_stripes_o  <= 4'h1;
    end else if (fmt_global_r[BIT_SUPPLY_1V8]) begin
      data_stripes_o <= stripes(drive_r[1:0]);
      dco_stripes_o  <= stripes(drive_r[5:4]);
    end else begin
      data_stripes_o <= stripes(drive_r[3:2]);
      dco_stripes_o  <= stripes(drive_r[7:6]);
    end
  end

  // Fine delay is analog, far below one clock period; only the tap code and the two enables leave
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fine_dly_o <= '0;
    end else begin
      fine_dly_o.clk_en  <= delay_r[BIT_DCO_DLY_EN];
      fine_dly_o.data_en <= delay_r[BIT_DATA_DLY_EN];
      fine_dly_o.code    <= (delay_r[2:0] > FINE_CODE_MAX) ? FINE_CODE_MAX
                                                           : delay_r[2:0];
    end
  end

  // Output clock only; the sample latch below uses the undelayed strobe
  aoc_phase_delay #(
    .MAX_DLY (6)
  ) u_phase (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .strobe_i  (sample_strobe_i),
    .phase_i   (phase_r[2:0]),
    .invert_i  (phase_r[BIT_DCO_INVERT]),
    .dco_o     (data_clock_out_o)
  );

  logic [11:0] raw      [2];
  logic [3:0]  tmode    [2];
  logic [11:0] word_nxt [2];
  logic [11:0] word_r   [2];
  logic [15:0] user_word;
  logic        mux_phase_r;

  assign raw[0]    = sample_a_i;
  assign raw[1]    = sample_b_i;
  assign tmode[0]  = test_mode_a_i;
  assign tmode[1]  = test_mode_b_i;
  assign user_word = {user_high_r, user_low_r};

  generate
    for (gc = 0; gc < 2; gc++) begin : g_chan
      logic signed [13:0] sum;
      logic [11:0]        trimmed;
      logic [11:0]        twos;
      logic [11:0]        coded;

      // Saturate rather than wrap so trim never folds full scale over
      assign sum = $signed({2'b00, raw[gc]}) + 14'($signed(offset_r[gc]));
      assign trimmed = (sum < 14'sd0) ? 12'h000 :
                       (sum > 14'sd4095) ? 12'hFFF : sum[11:0];
      assign twos = {~trimmed[11], trimmed[10:0]};

      always_comb begin
        unique case (fmt_local_r[gc][1:0])
          FMT_TWOS: coded = twos;
          FMT_GRAY: coded = twos ^ {1'b0, twos[11:1]};
          default:  coded = trimmed;
        endcase
        if (tmode[gc] == TEST_USER_INPUT) begin
          word_nxt[gc] = user_word[15:4];
        end else if (fmt_local_r[gc][BIT_INVERT]) begin
          word_nxt[gc] = ~coded;
        end else begin
          word_nxt[gc] = coded;
        end
      end

      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          word_r[gc] <= 12'h000;
        end else if (sample_strobe_i) begin
          word_r[gc] <= word_nxt[gc];
        end
      end

      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          data_en_o[gc] <= 1'b0;
        end else begin
          data_en_o[gc] <= ~fmt_local_r[gc][BIT_OUT_DISABLE];
        end
      end
    end
  endgenerate

  // Interleave alternates A and B words on both buses, one per strobe
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mux_phase_r <= 1'b0;
    end else if (!fmt_global_r[BIT_MUX_EN]) begin
      mux_phase_r <= 1'b0;
    end else if (sample_strobe_i) begin
      mux_phase_r <= ~mux_phase_r;
    end
  end

  always_comb begin
    if (fmt_global_r[BIT_MUX_EN]) begin
      data_a_o = mux_phase_r ? word_r[1] : word_r[0];
      data_b_o = data_a_o;
    end else begin
      data_a_o = word_r[0];
      data_b_o = word_r[1];
    end
  end

  // Self-test: run a fixed count, folding output words into a signature
  logic        st_en_d_r;
  logic [31:0] st_cnt_r;
  logic        st_start;

  assign st_start = self_test_r[BIT_SELF_TEST_EN] & ~st_en_d_r;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_en_d_r <= 1'b0;
    end else begin
      st_en_d_r <= self_test_r[BIT_SELF_TEST_EN];
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      self_test_busy_o <= 1'b0;
      st_cnt_r         <= 32'h0;
    end else if (st_start) begin
      self_test_busy_o <= 1'b1;
      st_cnt_r         <= 32'(BIST_LEN);
    end else if (self_test_busy_o) begin
      st_cnt_r <= st_cnt_r - 32'h1;
      if (st_cnt_r == 32'h1) begin
        self_test_busy_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      self_test_sig_o <= BIST_SEED;
    end else if (st_start && self_test_r[BIT_SELF_TEST_INIT]) begin
      self_test_sig_o <= BIST_SEED;
    end else if (self_test_busy_o && sample_strobe_i) begin
      self_test_sig_o <= {self_test_sig_o[14:0],
                          self_test_sig_o[15] ^ self_test_sig_o[4] ^
                          self_test_sig_o[2] ^ self_test_sig_o[1]}
                         ^ {4'h0, word_r[0] ^ word_r[1]};
    end
  end

endmodule

// ---- tb/aoc_cfg_props.sv ----
/*
 * Port checker for the output configuration slice.
 * Assumes a bind from the bench top and one clock domain on sys_clk_i.
 */
`timescale 1ns/10ps
module aoc_cfg_props
  import aoc_pkg::*;
#(
  parameter int BIST_LEN = 8
) (
  input  wire logic       sys_clk_i,        // Clock
  input  wire logic       nrst_i,           // Reset, active low
  input  aoc_cfg_req_t    cfg_req_i,        // Register request
  input  wire logic [7:0] cfg_rdata_o,      // Read data
  input  wire logic       cfg_ack_o,        // Access done
  input  wire logic       sample_strobe_i,  // Divider strobe
  input  wire logic       data_clock_out_o, // Data clock
  input  wire logic [3:0] data_stripes_o,   // Data drive
  input  wire logic [3:0] dco_stripes_o,    // Clock drive
  input  aoc_fine_dly_t   fine_dly_o,       // Fine delay
  input  wire logic       self_test_busy_o  // Self-test running
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  logic       sup_r;
  logic [7:0] cnt_r;
  // Supply choice decides which drive fields are live
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) sup_r <= 1'b0;
    else if (cfg_req_i.wr && cfg_req_i.addr == ADDR_OUT_FORMAT) sup_r <= cfg_req_i.wdata[7];
  end
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) cnt_r <= 8'h00;
    else cnt_r <= self_test_busy_o ? cnt_r + 8'h01 : 8'h00;
  end
  function automatic logic [3:0] th(input logic [1:0] c);
    return 4'hF >> (2'h3 - c);
  endfunction
  sequence req_s;
    cfg_req_i.wr || cfg_req_i.rd;
  endsequence
  sequence drive_wr_s;
    cfg_req_i.wr && cfg_req_i.addr == ADDR_DRIVE ##1 !cfg_req_i.wr;
  endsequence
  sequence delay_wr_s;
    cfg_req_i.wr && cfg_req_i.addr == ADDR_FINE_DELAY ##1 !cfg_req_i.wr;
  endsequence
  ack_after_req_a: assert property (req_s |=> cfg_ack_o)
    else $error("no ack after request");
  ack_only_req_a: assert property (!(cfg_req_i.wr || cfg_req_i.rd) |=> !cfg_ack_o)
    else $error("ack without request");
  rdata_hold_a: assert property (!cfg_req_i.rd |=> $stable(cfg_rdata_o))
    else $error("read data moved without read");
  unmapped_zero_a: assert property (cfg_req_i.rd && cfg_req_i.addr == 8'h11
    |=> cfg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  stripe_code_a: assert property (data_stripes_o inside {4'h1, 4'h3, 4'h7, 4'hF})
    else $error("data stripes not thermometer");
  drive_write_a: assert property (drive_wr_s |-> ##1 data_stripes_o == th(sup_r ?
    $past(cfg_req_i.wdata[1:0], 2) : $past(cfg_req_i.wdata[3:2], 2)))
    else $error("data stripes do not follow drive write");
  fine_code_max_a: assert property (fine_dly_o.code <= FINE_CODE_MAX)
    else $error("fine delay code above six");
  fine_write_a: assert property (delay_wr_s |-> ##1
    {fine_dly_o.clk_en, fine_dly_o.data_en} ==
    {$past(cfg_req_i.wdata[7], 2), $past(cfg_req_i.wdata[5], 2)})
    else $error("fine delay enables do not follow write");
  bist_length_a: assert property ($fell(self_test_busy_o) |-> cnt_r == 8'(BIST_LEN))
    else $error("self-test length wrong");
  dco_follow_a: assert property (sample_strobe_i |-> ##[1:7] data_clock_out_o)
    else $error("data clock missing after strobe");
endmodule

// ---- tb/aoc_host_model.sv ----
/*
 * Serial port host model issuing one-cycle register requests.
 * Assumes requests launch at the falling edge of sys_clk_i.
 */
`timescale 1ns/10ps
module aoc_host_model
  import aoc_pkg::*;
(
  input  wire logic       sys_clk_i,   // System clock
  input  wire logic       cfg_ack_i,   // Access done
  input  wire logic [7:0] cfg_rdata_i, // Read data
  output aoc_cfg_req_t    cfg_req_o    // Request to the slice
);
  logic ok;
  initial cfg_req_o = '0;
  // Writes go to both channels, reads return channel A
  task automatic access(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge sys_clk_i);
    cfg_req_o = '{wr: w, rd: !w, chan_sel: w ? 2'h3 : 2'h1, addr: a, wdata: d};
    @(negedge sys_clk_i);
    cfg_req_o = '0;
    ok = cfg_ack_i;
    q = cfg_rdata_i;
  endtask
endmodule

// ---- tb/test_adc_output_config_regs.sv ----
/*
 * Self-checking bench for the output configuration slice.
 * Assumes a 20 MHz clock and a short self-test length of 8 cycles.
 */
`timescale 1ns/10ps
module test_adc_output_config_regs
  import aoc_pkg::*;
;
  localparam int BIST_LEN = 8;
  logic          sys_clk_i, nrst_i, strobe, busy, data_clock_out, ack;
  aoc_cfg_req_t  req;
  aoc_fine_dly_t fdly;
  logic [7:0]    q, trim, lo, hi, d;
  logic [11:0]   sa, sb, da, db;
  logic [3:0]    tma, tmb, dstr, cstr;
  logic [1:0]    den;
  logic [15:0]   sig;
  logic [31:0]   rs;
  logic [7:0]    mdl [256];
  logic [7:0]    al [9] = '{8'h0E, 8'h10, 8'h14, 8'h15, 8'h16, 8'h17, 8'h19, 8'h1A, 8'h11};
  int            failures, n_checks, cyc, j, k;

  aoc_output_config #(.BIST_LEN(BIST_LEN)) i_aoc_output_config (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .cfg_req_i(req), .cfg_rdata_o(q),
    .cfg_ack_o(ack), .sample_strobe_i(strobe), .sample_a_i(sa), .sample_b_i(sb),
    .test_mode_a_i(tma), .test_mode_b_i(tmb), .data_a_o(da), .data_b_o(db),
    .data_en_o(den), .data_clock_out_o(data_clock_out), .data_stripes_o(dstr), .dco_stripes_o(cstr),
    .fine_dly_o(fdly), .self_test_busy_o(busy), .self_test_sig_o(sig));
  aoc_host_model i_aoc_host_model (.sys_clk_i(sys_clk_i), .cfg_ack_i(ack),
    .cfg_rdata_i(q), .cfg_req_o(req));

  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function automatic logic [3:0] th(input logic [1:0] c);
    return 4'hF >> (2'h3 - c);
  endfunction
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      8'h0E: return MASK_SELF_TEST;
      8'h14: return MASK_FMT_LOCAL | MASK_FMT_GLOBAL;
      8'h16: return MASK_CLK_PHASE;
      8'h17: return MASK_FINE_DELAY;
      8'h10, 8'h15, 8'h19, 8'h1A: return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction
  // Trim saturates before formatting
  function automatic logic [11:0] fm(input logic [11:0] r, input logic [7:0] t, input int c);
    int v;
    logic [11:0] e;
    v = int'(r) + int'($signed(t));
    e = v < 0 ? 12'h000 : v > 4095 ? 12'hFFF : 12'(v);
    if (c == 1 || c == 2) e = e ^ 12'h800;
    if (c == 2) e = e ^ (e >> 1);
    return e;
  endfunction
  task automatic chk_out(input logic [15:0] g, e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_reg(input logic [7:0] g, e);
    chk_out({8'h00, g}, {8'h00, e});
  endtask
  task automatic wr(input logic [7:0] a, v);
    i_aoc_host_model.access(1'b1, a, v, d);
    mdl[a] = v & msk(a);
  endtask
  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] r;
    i_aoc_host_model.access(1'b0, a, 8'h00, r);
    chk_reg({7'h00, i_aoc_host_model.ok}, 8'h01);
    chk_reg(r, mdl[a]);
  endtask
  task automatic pulse();
    strobe = 1'b1;
    @(negedge sys_clk_i);
    strobe = 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end

  initial begin
    {nrst_i, strobe, sa, sb, tma, tmb, failures, n_checks, cyc} = '0;
    rs = 32'hFEC19805;
    mdl = '{default: 8'h00};
    mdl[ADDR_DRIVE] = RST_DRIVE;
    repeat (2) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    @(negedge sys_clk_i);
    chk_out({8'h00, dstr, cstr}, 16'h0011);
    chk_out({13'h0, busy, den}, 16'h0003);
    foreach (al[i]) rd_chk(al[i]);
    foreach (al[i]) wr(al[i], 8'(xs()));
    foreach (al[i]) rd_chk(al[i]);
    $display("test registers done");
    for (k = 0; k < 16; k++) begin
      trim = 8'(xs());
      wr(ADDR_OFFSET_TRIM, trim);
      wr(ADDR_OUT_FORMAT, 8'(k % 4));
      sa = 12'(xs());
      sb = 12'(xs());
      pulse();
      chk_out({4'h0, da}, {4'h0, fm(sa, trim, k % 4)});
      chk_out({4'h0, db}, {4'h0, fm(sb, trim, k % 4)});
    end
    $display("test format done");
    lo = 8'(xs());
    hi = 8'(xs());
    wr(ADDR_USER_LOW, lo);
    wr(ADDR_USER_HIGH, hi);
    tma = TEST_USER_INPUT;
    pulse();
    chk_out({4'h0, da}, {4'h0, hi, lo[7:4]});
    chk_out({4'h0, db}, {4'h0, fm(sb, trim, 3)});
    tma = 4'h0;
    $display("test user word done");
    wr(ADDR_OUT_FORMAT, 8'h17);
    pulse();
    chk_out({4'h0, da}, {4'h0, ~fm(sa, trim, 3)});
    chk_out({14'h0, den}, 16'h0000);
    // Interleave phase flips on every strobe, so B shows first
    wr(ADDR_OUT_FORMAT, 8'h23);
    sb = 12'(xs());
    for (k = 0; k < 2; k++) begin
      pulse();
      chk_out({4'h0, da}, {4'h0, fm(k ? sa : sb, trim, 3)});
      chk_out({4'h0, db}, {4'h0, fm(k ? sa : sb, trim, 3)});
      @(negedge sys_clk_i);
    end
    chk_out({14'h0, den}, 16'h0003);
    $display("test invert and interleave done");
    for (k = 0; k < 4; k++) begin
      wr(ADDR_OUT_FORMAT, (k % 2) ? 8'h83 : 8'h03);
      wr(ADDR_DRIVE, 8'(xs()));
      @(negedge sys_clk_i);
      d = mdl[ADDR_DRIVE];
      chk_out({8'h00, dstr, cstr}, (k % 2) ? {8'h00, th(d[1:0]), th(d[5:4])}
                                         : {8'h00, th(d[3:2]), th(d[7:6])});
    end
    $display("test drive done");
    for (j = 0; j < 7; j++) begin
      wr(ADDR_CLK_PHASE, 8'(j));
      strobe = 1'b1;
      k = 0;
      do begin
        @(negedge sys_clk_i);
        strobe = 1'b0;
        k++;
        if (k == 1) chk_out({4'h0, da}, {4'h0, fm(sa, trim, 3)});
      end while (data_clock_out !== 1'b1 && k < 12);
      chk_out(16'(k), 16'(j + 1));
    end
    $display("test phase done");
    for (j = 0; j < 8; j++) begin
      wr(ADDR_FINE_DELAY, 8'(j) | ((j % 2) ? 8'h80 : 8'h00) | ((j > 3) ? 8'h20 : 8'h00));
      @(negedge sys_clk_i);
      chk_out(16'(fdly), {11'h0, j % 2 == 1, j > 3, (j == 7) ? 3'h6 : 3'(j)});
    end
    $display("test fine delay done");
    wr(ADDR_SELF_TEST, 8'h00);
    wr(ADDR_SELF_TEST, 8'h05);
    k = int'(busy);
    repeat (20) begin
      @(negedge sys_clk_i);
      if (busy === 1'b1) k++;
    end
    chk_out(16'(k), 16'(BIST_LEN));
    chk_out(sig, BIST_SEED);
    $display("test self-test done");
    print_verdict();
  end
endmodule

bind aoc_output_config aoc_cfg_props #(.BIST_LEN(BIST_LEN)) i_aoc_cfg_props (
  .sys_clk_i, .nrst_i, .cfg_req_i, .cfg_rdata_o, .cfg_ack_o, .sample_strobe_i,
  .data_clock_out_o, .data_stripes_o, .dco_stripes_o, .fine_dly_o, .self_test_busy_o);
